/* core/vti_pkg.sv */
// Constants shared by the VLAN tag ingress and egress block
package vti_pkg;
	localparam logic [11:0] VTI_ADDR_CPU_VLAN  = 12'h000;
	localparam logic [11:0] VTI_ADDR_TBL_IDX   = 12'h004;
	localparam logic [11:0] VTI_ADDR_TBL_VID   = 12'h008;
	localparam logic [11:0] VTI_ADDR_TBL_MEMB  = 12'h00C;
	localparam logic [11:0] VTI_ADDR_TBL_UNTAG = 12'h010;
	localparam logic [11:0] VTI_ADDR_STATUS    = 12'h014;
	localparam logic [11:0] VTI_ADDR_DROPS     = 12'h018;
	localparam logic [11:0] VTI_ADDR_PORT_BASE = 12'h040;

	localparam int VTI_PC_PORT_DEFAULT_VLAN_LSB   = 0;
	localparam int VTI_PC_MODE_LSB   = 12;
	localparam int VTI_PC_TAGONLY    = 14;
	localparam int VTI_PC_IFILT      = 15;
	localparam int VTI_TV_VALID      = 16;
	localparam int VTI_TV_UNUSED     = 17;

	localparam logic [11:0] VTI_VID_NULL    = 12'h000;
	localparam logic [11:0] VTI_VID_RSVD    = 12'hFFF;
	localparam logic [11:0] VTI_VID_DEFAULT = 12'h001;
	localparam logic [11:0] VTI_CPU_VLAN_RST = 12'h001;

	localparam logic [15:0] VTI_TPID          = 16'h8100;
	localparam logic [3:0]  VTI_TAG_BYTES     = 4'h4;
	localparam logic [3:0]  VTI_TAG_INS_OFFSET = 4'hC;

	typedef enum logic [1:0] {
		VTI_MODE_NONE     = 2'h0,
		VTI_MODE_CUSTOMER = 2'h1,
		VTI_MODE_PROVIDER = 2'h2
	} vti_mode_e;

	localparam logic [1:0] VTI_MODE_BAD = 2'h3;
endpackage : vti_pkg

/* core/vti_vid_lookup.sv */
// Associative search of the VLAN table for one identifier
`timescale 1ns/1ps
`default_nettype none
module vti_vid_lookup
	import vti_pkg::*;
#(
	parameter int ENTRIES = 64,
	parameter int IW      = 6
)(
	input  wire logic [ENTRIES-1:0][11:0] vids,
	input  wire logic [ENTRIES-1:0]       valid,
	input  wire logic [11:0]              key,
	output logic                          hit,
	output logic [IW-1:0]                 idx
);
	// Lowest index wins if software ever loads a duplicate identifier
	always_comb
	begin
		hit = 1'b0;
		idx = '0;
		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (valid[i] && vids[i] == key)
			begin
				hit = 1'b1;
				idx = IW'(i);
			end
		end
	end
endmodule : vti_vid_lookup
`default_nettype wire

/* core/vti_tag_engine.sv */
// Per-port VLAN classification, filtering and tag push/pop decisions
// Function
// (RULE_01) Tagged frames classified by their tag identifier
// (RULE_02) Default VLAN rejects 0 and 4095
// (RULE_03) Default VLAN resets to 1
// (RULE_04) Three double-tag modes per port
// (RULE_05) Customer tunnel pushes outer default-VLAN tag
// (RULE_06) Customer tunnel egress strips outer tag
// (RULE_07) Software sets customer tunnel egress untagged
// (RULE_08) Provider uplink keeps outer tag, egress tagged
// (RULE_09) Admit-all accepts tagged and untagged
// (RULE_10) Tagged-only drops untagged frames
// (RULE_11) Ingress filter drops non-member tagged frames
// (RULE_12) Ingress filter locked in tunnel modes
// (RULE_13) CPU frames need management VLAN member port
// (RULE_14) Management VLAN resets to 1
// (RULE_15) Entries take identifiers 1..4094; VLAN 1 default
// (RULE_16) Table holds at most 64 entries
// (RULE_17) Memberless VLAN is unused, carries nothing
// (RULE_18) Untagged egress rule sends without tag
// (RULE_19) Tagged egress rule sends with tag
// (RULE_20) Untagged frames take port default VLAN
// (RULE_21) Standard 4-byte tag after source, FCS redone
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vti_tag_engine
	import vti_pkg::*;
#(
	parameter int NUM_PORTS = 10,
	parameter int ENTRIES   = 64
)(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic                              pready,
	output logic [31:0]                       prdata,
	output logic                              pslverr,
	input  wire logic                         ing_valid,
	input  wire logic [$clog2(NUM_PORTS)-1:0] ing_port,
	input  wire logic                         ing_tagged,
	input  wire logic [11:0]                  ing_vid,
	input  wire logic                         ing_to_cpu,
	output logic                              ing_done,
	output logic                              ing_accept,
	output logic [11:0]                       ing_vlan,
	output logic                              ing_push_outer,
	output logic [11:0]                       ing_outer_vid,
	output logic                              ing_cpu_ok,
	output logic                              ing_fcs_redo,
	input  wire logic                         eg_valid,
	input  wire logic [$clog2(NUM_PORTS)-1:0] eg_port,
	input  wire logic [11:0]                  eg_vid,
	input  wire logic                         eg_double,
	output logic                              eg_done,
	output logic                              eg_forward,
	output logic                              eg_tagged,
	output logic                              eg_strip_outer,
	output logic                              eg_fcs_redo,
	output logic [15:0]                       tag_tpid,
	output logic [3:0]                        tag_offset
);
	localparam int PW = $clog2(NUM_PORTS);
	localparam int IW = $clog2(ENTRIES);

	if (NUM_PORTS < 2 || NUM_PORTS > 16)
		$error("NUM_PORTS must be 2..16");
	if (ENTRIES < 2 || ENTRIES > 64) // [RULE_16]
		$error("ENTRIES must be 2..64");

	// Per-port configuration
	logic [NUM_PORTS-1:0][11:0] port_default_vlan_q, port_default_vlan_d;
	vti_mode_e [NUM_PORTS-1:0]  mode_q, mode_d;
	logic [NUM_PORTS-1:0]       tagonly_q, tagonly_d;
	logic [NUM_PORTS-1:0]       ifilt_q, ifilt_d;
	// VLAN table
	logic [ENTRIES-1:0][11:0]        tvid_q, tvid_d;
	logic [ENTRIES-1:0]              tval_q, tval_d;
	logic [ENTRIES-1:0][NUM_PORTS-1:0] tmem_q, tmem_d;
	logic [ENTRIES-1:0][NUM_PORTS-1:0] tunt_q, tunt_d;
	logic [11:0]     cpu_vlan_q, cpu_vlan_d;
	logic [IW-1:0]   tidx_q, tidx_d;
	logic [31:0]     drops_q, drops_d;
	logic [31:0]     prdata_q, prdata_d;
	logic            perr_q, perr_d;
	// Decision outputs
	logic            idone_q, idone_d, iacc_q, iacc_d, ipush_q, ipush_d;
	logic            icpu_q, icpu_d, ifcs_q, ifcs_d;
	logic [11:0]     ivlan_q, ivlan_d, iouter_q, iouter_d;
	logic            edone_q, edone_d, efwd_q, efwd_d, etag_q, etag_d;
	logic            estrip_q, estrip_d, efcs_q, efcs_d;

	// Lookups
	logic [11:0]   ikey;
	logic          ihit, ehit, chit;
	logic [IW-1:0] iidx, eidx, cidx;

	vti_vid_lookup #(.ENTRIES(ENTRIES), .IW(IW)) u_ing_lookup (
		.vids  (tvid_q),
		.valid (tval_q),
		.key   (ikey),
		.hit   (ihit),
		.idx   (iidx)
	);
	vti_vid_lookup #(.ENTRIES(ENTRIES), .IW(IW)) u_eg_lookup (
		.vids  (tvid_q),
		.valid (tval_q),
		.key   (eg_vid),
		.hit   (ehit),
		.idx   (eidx)
	);
	vti_vid_lookup #(.ENTRIES(ENTRIES), .IW(IW)) u_cpu_lookup (
		.vids  (tvid_q),
		.valid (tval_q),
		.key   (cpu_vlan_q),
		.hit   (chit),
		.idx   (cidx)
	);

	// Ingress classification key
	logic      iport_ok;
	vti_mode_e imode;
	logic [11:0] ipvid;
	always_comb
	begin
		iport_ok = 32'(ing_port) < NUM_PORTS;
		imode    = iport_ok ? mode_q[ing_port] : VTI_MODE_NONE;
		ipvid    = iport_ok ? port_default_vlan_q[ing_port] : VTI_VID_DEFAULT;
		// Tunnel ports classify into the service VLAN; priority tags count as untagged
		if (imode == VTI_MODE_CUSTOMER)
			ikey = ipvid; // [RULE_05]
		else if (ing_tagged && ing_vid != VTI_VID_NULL)
			ikey = ing_vid; // [RULE_01]
		else
			ikey = ipvid; // [RULE_20]
	end

	// APB decode
	logic        acc, setup, wr_ok, is_port;
	logic [31:0] rd;
	logic [PW-1:0] pidx;
	logic [11:0] poff;
	logic        popmap;
	logic [ENTRIES-1:0] tused;
	logic [$clog2(ENTRIES+1)-1:0] nvalid;

	always_comb
	begin
		setup = psel && !penable;
		acc   = psel && penable;
		poff  = paddr - VTI_ADDR_PORT_BASE;
		pidx  = poff[PW+1:2];
		is_port = paddr >= VTI_ADDR_PORT_BASE && poff[11:2] < 10'(NUM_PORTS)
			&& paddr[1:0] == 2'h0;
		nvalid = '0;
		for (int i = 0; i < ENTRIES; i++)
		begin
			tused[i] = tval_q[i] && tmem_q[i] == '0; // [RULE_17]
			nvalid   = nvalid + ($clog2(ENTRIES+1))'(tval_q[i]);
		end
		popmap = 1'b1;
		rd     = 32'h00000000;
		if (is_port)
		begin
			rd[VTI_PC_PORT_DEFAULT_VLAN_LSB +: 12] = port_default_vlan_q[pidx];
			rd[VTI_PC_MODE_LSB +: 2]  = mode_q[pidx];
			rd[VTI_PC_TAGONLY]        = tagonly_q[pidx];
			rd[VTI_PC_IFILT]          = ifilt_q[pidx];
		end
		else
		begin
			unique case (paddr)
				VTI_ADDR_CPU_VLAN:  rd[11:0] = cpu_vlan_q;
				VTI_ADDR_TBL_IDX:   rd[IW-1:0] = tidx_q;
				VTI_ADDR_TBL_VID:
				begin
					rd[11:0]          = tvid_q[tidx_q];
					rd[VTI_TV_VALID]  = tval_q[tidx_q];
					rd[VTI_TV_UNUSED] = tused[tidx_q];
				end
				VTI_ADDR_TBL_MEMB:  rd[NUM_PORTS-1:0] = tmem_q[tidx_q];
				VTI_ADDR_TBL_UNTAG: rd[NUM_PORTS-1:0] = tunt_q[tidx_q];
				VTI_ADDR_STATUS:    rd[$clog2(ENTRIES+1)-1:0] = nvalid;
				VTI_ADDR_DROPS:     rd = drops_q;
				default:            popmap = 1'b0;
			endcase
		end
	end

	// Next state: registers, APB and decisions
	logic [11:0] wvid;
	logic [1:0]  wmode;
	always_comb
	begin
		port_default_vlan_d = port_default_vlan_q; mode_d = mode_q; tagonly_d = tagonly_q; ifilt_d = ifilt_q;
		tvid_d = tvid_q; tval_d = tval_q; tmem_d = tmem_q; tunt_d = tunt_q;
		cpu_vlan_d = cpu_vlan_q;
		tidx_d     = tidx_q;
		drops_d    = drops_q;
		prdata_d   = prdata_q;
		perr_d     = perr_q;
		wvid       = pwdata[11:0];
		wmode      = pwdata[VTI_PC_MODE_LSB +: 2];
		wr_ok      = 1'b0;

		// Answer is prepared during setup, shown through the one-cycle access phase
		if (setup)
		begin
			prdata_d = pwrite ? 32'h00000000 : rd;
			perr_d   = !popmap && !is_port;
			if (pwrite && is_port)
				perr_d = wvid == VTI_VID_NULL || wvid == VTI_VID_RSVD // [RULE_02]
					|| wmode == VTI_MODE_BAD; // [RULE_04]
			if (pwrite && (paddr == VTI_ADDR_TBL_VID || paddr == VTI_ADDR_CPU_VLAN))
				perr_d = wvid == VTI_VID_NULL || wvid == VTI_VID_RSVD; // [RULE_15]
		end
		wr_ok = acc && pwrite && !perr_q;

		if (wr_ok && is_port)
		begin
			port_default_vlan_d[pidx]    = wvid; // [RULE_02]
			mode_d[pidx]    = vti_mode_e'(wmode); // [RULE_04]
			tagonly_d[pidx] = pwdata[VTI_PC_TAGONLY];
			// Filter bit frozen while the port is already tunnelling
			if (mode_q[pidx] == VTI_MODE_NONE) // [RULE_12]
				ifilt_d[pidx] = pwdata[VTI_PC_IFILT];
		end
		else if (wr_ok)
		begin
			unique case (paddr)
				VTI_ADDR_CPU_VLAN:  cpu_vlan_d = wvid;
				VTI_ADDR_TBL_IDX:   tidx_d = pwdata[IW-1:0]; // [RULE_16]
				VTI_ADDR_TBL_VID:
				begin
					tvid_d[tidx_q] = wvid; // [RULE_15]
					tval_d[tidx_q] = pwdata[VTI_TV_VALID];
				end
				VTI_ADDR_TBL_MEMB:  tmem_d[tidx_q] = pwdata[NUM_PORTS-1:0];
				VTI_ADDR_TBL_UNTAG: tunt_d[tidx_q] = pwdata[NUM_PORTS-1:0];
				VTI_ADDR_DROPS:     drops_d = 32'h00000000;
				default:            drops_d = drops_q;
			endcase
		end

		// Ingress decision
		idone_d = ing_valid;
		ivlan_d = ikey;
		iouter_d = ipvid;
		ipush_d = iport_ok && imode == VTI_MODE_CUSTOMER; // [RULE_05]
		iacc_d  = iport_ok && ihit && tmem_q[iidx] != '0; // [RULE_17]
		if (iport_ok && tagonly_q[ing_port] && !ing_tagged)
			iacc_d = 1'b0; // [RULE_10]
		// Admit-all passes both kinds on to the membership checks [RULE_09]
		if (iport_ok && ifilt_q[ing_port] && ing_tagged && !tmem_q[iidx][ing_port])
			iacc_d = 1'b0; // [RULE_11]
		icpu_d = iacc_d && ing_to_cpu && chit && tmem_q[cidx][ing_port]; // [RULE_13]
		ifcs_d = iacc_d && ipush_d; // [RULE_21]
		if (ing_valid && !iacc_d && !(wr_ok && paddr == VTI_ADDR_DROPS))
			drops_d = drops_q + 32'h00000001;

		// Egress decision
		edone_d  = eg_valid;
		efwd_d   = 32'(eg_port) < NUM_PORTS && ehit && tmem_q[eidx][eg_port]; // [RULE_17]
		etag_d   = efwd_d && !tunt_q[eidx][eg_port]; // [RULE_18] [RULE_19]
		// Customer side loses the service tag; uplink keeps it as is
		estrip_d = efwd_d && eg_double && mode_q[eg_port] == VTI_MODE_CUSTOMER; // [RULE_06]
		if (efwd_d && mode_q[eg_port] == VTI_MODE_PROVIDER)
			estrip_d = 1'b0; // [RULE_08]
		efcs_d = efwd_d && (estrip_d || etag_d != eg_double); // [RULE_21]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				port_default_vlan_q[p] <= VTI_VID_DEFAULT; // [RULE_03]
				mode_q[p] <= VTI_MODE_NONE;
			end
			tagonly_q <= '0;
			ifilt_q   <= '0;
			for (int i = 0; i < ENTRIES; i++)
			begin
				tvid_q[i] <= VTI_VID_NULL;
				tmem_q[i] <= '0;
				tunt_q[i] <= '0;
			end
			tvid_q[0] <= VTI_VID_DEFAULT; // [RULE_15]
			tmem_q[0] <= '1;
			tunt_q[0] <= '1;
			tval_q <= ENTRIES'(1);
			cpu_vlan_q <= VTI_CPU_VLAN_RST; // [RULE_14]
			tidx_q   <= '0;
			drops_q  <= 32'h00000000;
			prdata_q <= 32'h00000000;
			perr_q   <= 1'b0;
			idone_q <= 1'b0; iacc_q <= 1'b0; ipush_q <= 1'b0; icpu_q <= 1'b0; ifcs_q <= 1'b0;
			ivlan_q <= VTI_VID_NULL; iouter_q <= VTI_VID_NULL;
			edone_q <= 1'b0; efwd_q <= 1'b0; etag_q <= 1'b0; estrip_q <= 1'b0; efcs_q <= 1'b0;
		end
		else
		begin
			port_default_vlan_q <= port_default_vlan_d; mode_q <= mode_d; tagonly_q <= tagonly_d; ifilt_q <= ifilt_d;
			tvid_q <= tvid_d; tval_q <= tval_d; tmem_q <= tmem_d; tunt_q <= tunt_d;
			cpu_vlan_q <= cpu_vlan_d;
			tidx_q   <= tidx_d;
			drops_q  <= drops_d;
			prdata_q <= prdata_d;
			perr_q   <= perr_d;
			idone_q <= idone_d; iacc_q <= iacc_d; ipush_q <= ipush_d; icpu_q <= icpu_d;
			ifcs_q <= ifcs_d; ivlan_q <= ivlan_d; iouter_q <= iouter_d;
			edone_q <= edone_d; efwd_q <= efwd_d; etag_q <= etag_d;
			estrip_q <= estrip_d; efcs_q <= efcs_d;
		end
	end

	assign pready         = 1'b1;
	assign prdata         = prdata_q;
	assign pslverr        = perr_q && acc;
	assign ing_done       = idone_q;
	assign ing_accept     = iacc_q && idone_q;
	assign ing_vlan       = ivlan_q;
	assign ing_push_outer = ipush_q && iacc_q && idone_q;
	assign ing_outer_vid  = iouter_q;
	assign ing_cpu_ok     = icpu_q && idone_q;
	assign ing_fcs_redo   = ifcs_q && idone_q;
	assign eg_done        = edone_q;
	assign eg_forward     = efwd_q && edone_q;
	assign eg_tagged      = etag_q && edone_q;
	assign eg_strip_outer = estrip_q && edone_q;
	assign eg_fcs_redo    = efcs_q && edone_q;
	// Standard tag placed after both addresses
	assign tag_tpid       = VTI_TPID; // [RULE_21]
	assign tag_offset     = VTI_TAG_INS_OFFSET;
endmodule : vti_tag_engine
`default_nettype wire

/* tb/vti_tag_engine_props.sv */
// Concurrent checks on the VLAN tag engine ports
`timescale 1ns/1ps
`default_nettype none
module vti_tag_engine_props
	import vti_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        ing_valid,
	input wire logic        ing_done,
	input wire logic        ing_accept,
	input wire logic [11:0] ing_vlan,
	input wire logic        ing_push_outer,
	input wire logic [11:0] ing_outer_vid,
	input wire logic        ing_cpu_ok,
	input wire logic        ing_fcs_redo,
	input wire logic        eg_valid,
	input wire logic        eg_double,
	input wire logic        eg_done,
	input wire logic        eg_forward,
	input wire logic        eg_tagged,
	input wire logic        eg_strip_outer,
	input wire logic [15:0] tag_tpid,
	input wire logic [3:0]  tag_offset
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_port_zero;
		psel && !penable && pwrite && paddr == VTI_ADDR_PORT_BASE && pwdata[11:0] == 12'h000;
	endsequence
	sequence s_vid_rsvd;
		psel && !penable && pwrite && paddr == VTI_ADDR_TBL_VID && pwdata[11:0] == 12'hFFF;
	endsequence
	a_port_default_vlan_zero_err:
		assert property (s_port_zero ##1 s_access |-> pslverr) else $error("zero default VLAN taken");
	a_tbl_rsvd_err:
		assert property (s_vid_rsvd ##1 s_access |-> pslverr) else $error("reserved VLAN id taken");
	a_ing_done_next:
		assert property (ing_valid |=> ing_done) else $error("ingress answer missing");
	a_ing_idle_quiet:
		assert property (!ing_done |-> !(ing_accept || ing_cpu_ok || ing_fcs_redo))
		else $error("ingress flags outside answer");
	a_outer_vid_match:
		assert property (ing_done && ing_accept && ing_push_outer |-> ing_outer_vid == ing_vlan)
		else $error("outer tag id differs");
	a_fcs_on_push:
		assert property (ing_done |-> ing_fcs_redo == (ing_accept && ing_push_outer))
		else $error("ingress check sequence flag wrong");
	a_cpu_needs_accept:
		assert property (ing_cpu_ok |-> ing_accept) else $error("cpu delivery of dropped frame");
	a_eg_done_next:
		assert property (eg_valid |=> eg_done) else $error("egress answer missing");
	a_tag_needs_fwd:
		assert property (eg_tagged |-> eg_forward) else $error("tag on unforwarded frame");
	a_strip_single:
		assert property (eg_valid && !eg_double |=> !eg_strip_outer) else $error("strip on single tag");
	a_tag_format:
		assert property (tag_tpid == VTI_TPID && tag_offset == VTI_TAG_INS_OFFSET)
		else $error("tag format wrong");
endmodule : vti_tag_engine_props

bind vti_tag_engine vti_tag_engine_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pslverr, .ing_valid, .ing_done, .ing_accept, .ing_vlan, .ing_push_outer,
	.ing_outer_vid, .ing_cpu_ok, .ing_fcs_redo, .eg_valid, .eg_double, .eg_done, .eg_forward,
	.eg_tagged, .eg_strip_outer, .tag_tpid, .tag_offset);
`default_nettype wire

/* tb/vti_peer.sv */
// Link partner model handing frame descriptors to the engine
`timescale 1ns/1ps
`default_nettype none
module vti_peer (
	output logic        ing_valid,
	output logic [3:0]  ing_port,
	output logic        ing_tagged,
	output logic [11:0] ing_vid,
	output logic        ing_to_cpu,
	output logic        eg_valid,
	output logic [3:0]  eg_port,
	output logic [11:0] eg_vid,
	output logic        eg_double,
	input wire logic    pclk
);
	initial
	begin
		{ing_valid, ing_port, ing_tagged, ing_vid, ing_to_cpu} = '0;
		{eg_valid, eg_port, eg_vid, eg_double} = '0;
	end
	task automatic send(input logic [3:0] p, input logic t, input logic [11:0] v, input logic c,
		input logic [3:0] ep, input logic [11:0] ev, input logic d);
		@(posedge pclk);
		ing_valid <= 1'b1;
		{ing_port, ing_tagged, ing_vid, ing_to_cpu} <= {p, t, v, c};
		eg_valid <= 1'b1;
		{eg_port, eg_vid, eg_double} <= {ep, ev, d};
		@(posedge pclk);
		ing_valid <= 1'b0;
		eg_valid <= 1'b0;
		// Stale ingress port and both identifier fields scrambled so nothing leans on held values
		{ing_port, ing_vid, eg_vid} <= ~{p, v, ev};
	endtask : send
endmodule : vti_peer
`default_nettype wire

/* tb/test_vlan_tag_ingress_egress.sv */
// Self-checking bench for the VLAN tag engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module test_vlan_tag_ingress_egress import vti_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr, ing_vid, ing_vlan, ing_outer_vid, eg_vid;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  ing_port, eg_port, tag_offset;
	logic [15:0] tag_tpid;
	logic        ing_valid, ing_tagged, ing_to_cpu, ing_done, ing_accept, ing_push_outer;
	logic        ing_cpu_ok, ing_fcs_redo, eg_valid, eg_double, eg_done, eg_forward;
	logic        eg_tagged, eg_strip_outer, eg_fcs_redo;
	int          n_fail = 0;
	int          n_tests = 0;
	int          seed = 44457;
	int          nd = 0;
	int          cv = 1;
	int          pv[10], md[10], to[10], fl[10], tv[64], tl[64], tm[64], tu[64];
	int          vl[5] = '{1, 5, 10, 4094, 7};

	vti_tag_engine i_vti_tag_engine (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .ing_valid, .ing_port, .ing_tagged, .ing_vid, .ing_to_cpu,
		.ing_done, .ing_accept, .ing_vlan, .ing_push_outer, .ing_outer_vid, .ing_cpu_ok,
		.ing_fcs_redo, .eg_valid, .eg_port, .eg_vid, .eg_double, .eg_done, .eg_forward,
		.eg_tagged, .eg_strip_outer, .eg_fcs_redo, .tag_tpid, .tag_offset);
	vti_peer i_vti_peer (.pclk, .ing_valid, .ing_port, .ing_tagged, .ing_vid, .ing_to_cpu,
		.eg_valid, .eg_port, .eg_vid, .eg_double);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		report_and_stop;
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic ck(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : ck
	task automatic erw(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		`CHK(er, 1'b1)
	endtask : erw
	task automatic setv(int i, int v, int m, int u);
		{tv[i], tl[i], tm[i], tu[i]} = {v, 32'd1, m, u};
		apb(1'b1, VTI_ADDR_TBL_IDX, 32'(i));
		apb(1'b1, VTI_ADDR_TBL_VID, 32'(v) | 32'h00010000);
		apb(1'b1, VTI_ADDR_TBL_MEMB, 32'(m));
		apb(1'b1, VTI_ADDR_TBL_UNTAG, 32'(u));
	endtask : setv
	task automatic setp(int p, int v, int m, int t, int f);
		// Filter bit frozen once a tunnel mode is held
		if (md[p] == 0)
			fl[p] = f;
		{pv[p], md[p], to[p]} = {v, m, t};
		apb(1'b1, VTI_ADDR_PORT_BASE + 12'(4 * p), 32'(v + (m << 12) + (t << 14) + (f << 15)));
		`CHK(er, 1'b0)
	endtask : setp
	function automatic int find(int v);
		for (int i = 0; i < 64; i++)
			if (tl[i] != 0 && tv[i] == v)
				return i;
		return -1;
	endfunction : find
	task automatic frame(int p, int t, int v, int c, int ep, int ev, int d);
		int   cl, ci, mi, ei;
		logic acc, cm, fw, tg, st;
		cl = (md[p] == 1 || t == 0) ? pv[p] : v;
		ci = find(cl);
		acc = ci >= 0 && tm[ci] != 0 && !(to[p] && !t) && !(fl[p] && t && !tm[ci][p]);
		if (!acc)
			nd++;
		mi = find(cv);
		cm = acc && c && mi >= 0 && tm[mi][p];
		ei = find(ev);
		fw = ei >= 0 && tm[ei][ep];
		tg = fw && !tu[ei][ep];
		st = fw && d && md[ep] == 1;
		i_vti_peer.send(4'(p), t[0], 12'(v), c[0], 4'(ep), 12'(ev), d[0]);
		// Answers stand for one cycle; look mid-cycle, away from the launching edge
		@(negedge pclk);
		`CHK(ing_done, 1'b1)
		`CHK(eg_done, 1'b1)
		`CHK(ing_fcs_redo, logic'(acc && md[p] == 1))
		if (acc && md[p] == 1) `CHK(ing_outer_vid, 12'(pv[p]))
		`CHK(ing_accept, acc)
		if (acc) `CHK(ing_vlan, 12'(cl))
		if (acc) `CHK(ing_push_outer, logic'(md[p] == 1))
		`CHK(ing_cpu_ok, cm)
		`CHK(eg_forward, fw)
		`CHK(eg_tagged, tg)
		`CHK(eg_strip_outer, st)
		`CHK(eg_fcs_redo, logic'(fw && (st || tg != d[0])))
	endtask : frame
	function automatic int rn(int n);
		return {$random(seed)} % n;
	endfunction : rn
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		foreach (pv[i]) pv[i] = 1;
		{tv[0], tl[0], tm[0], tu[0]} = {32'd1, 32'd1, 32'h3FF, 32'h3FF};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		ck(VTI_ADDR_CPU_VLAN, 32'h00000001);
		ck(VTI_ADDR_PORT_BASE + 12'h024, 32'h00000001);
		ck(VTI_ADDR_TBL_VID, 32'h00010001);
		$display("test reset values done");
		erw(VTI_ADDR_PORT_BASE, 32'h00000000);
		erw(VTI_ADDR_PORT_BASE, 32'h00000FFF);
		erw(VTI_ADDR_PORT_BASE, 32'h00003002);
		erw(VTI_ADDR_TBL_VID, 32'h00010000);
		erw(VTI_ADDR_TBL_VID, 32'h00010FFF);
		erw(12'h01C, 32'h00000001);
		ck(VTI_ADDR_PORT_BASE, 32'h00000001);
		$display("test refusals done");
		setv(1, 5, 0, 0);
		ck(VTI_ADDR_TBL_VID, 32'h00030005);
		frame(0, 1, 5, 0, 0, 5, 0);
		$display("test unused entry done");
		setv(1, 5, 32'h0F3, 32'h003);
		setv(2, 10, 32'h3FF, 32'h0F4);
		setv(0, 1, 32'h3FE, 32'h3FE);
		setp(1, 5, 0, 1, 1);
		setp(2, 10, 1, 0, 0);
		setp(2, 10, 1, 0, 1);
		ck(VTI_ADDR_PORT_BASE + 12'h008, 32'h0000100A);
		setp(3, 10, 2, 0, 0);
		setp(4, 4094, 0, 0, 0);
		ck(VTI_ADDR_PORT_BASE + 12'h010, 32'h00000FFE);
		apb(1'b1, VTI_ADDR_DROPS, 32'h00000000);
		nd = 0;
		repeat (150) frame(rn(10), rn(2), vl[rn(5)], rn(2), rn(10), vl[rn(5)], rn(2));
		// Move the management VLAN so CPU delivery follows the new member set
		apb(1'b1, VTI_ADDR_CPU_VLAN, 32'h0000000A);
		cv = 10;
		ck(VTI_ADDR_CPU_VLAN, 32'h0000000A);
		repeat (150) frame(rn(10), rn(2), vl[rn(5)], rn(2), rn(10), vl[rn(5)], rn(2));
		ck(VTI_ADDR_DROPS, 32'(nd));
		$display("test frames done");
		for (int i = 3; i < 64; i++)
			setv(i, 100 + i, 1, 0);
		ck(VTI_ADDR_STATUS, 32'h00000040);
		$display("test table capacity done");
		report_and_stop;
	end
endmodule : test_vlan_tag_ingress_egress
`default_nettype wire
